// ---- rtl/byte_fifo.sv ----
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W:0] count_ff;
    logic push;
    logic pop;

    assign in_ready_o = count_ff != (PTR_W + 1)'(DEPTH);
    assign out_valid_o = count_ff != '0;
    assign out_data_o = mem_ff[rd_ptr_ff];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // Flush wins over a push or pop in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (flush_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule : byte_fifo

// ---- rtl/eeprom_pkg.sv ----
package eeprom_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PROG_TIME_NS = 5_000_000;
    // Longest time, so the count rounds down
    localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int SPIKE_NS = 24;
    // Least time, so the count rounds up
    localparam int FILT_CYCLES_DEF = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Array organisation
    localparam int BYTE_W = 8;
    localparam int MEM_BYTES = 8192;
    localparam int ADDR_W = 13;
    localparam int PAGE_BYTES = 32;
    localparam int OFF_W = 5;
    localparam int ADDR_HI_W = ADDR_W - BYTE_W;
    localparam int FIFO_DEPTH_DEF = 4;

    ////////////////////////////////////////////////////////////////////////
    // Slave byte layout
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int RW_BIT = 0;
    localparam int SEL_W = 3;
    // Device type code; value is arbitrary
    localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

    ////////////////////////////////////////////////////////////////////////
    // Bit counter positions
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    // Line levels at reset: bus idles high, straps read low
    localparam logic [1:0] BUS_RST_VAL = 2'h3;
    localparam logic [3:0] STRAP_RST_VAL = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEVSEL = 3'h1,
        ST_ADDR_HI = 3'h3,
        ST_ADDR_LO = 3'h2,
        ST_WDATA = 3'h6,
        ST_RDATA = 3'h7
    } bus_state_e;

endpackage : eeprom_pkg

// ---- rtl/line_filter.sv ----
`timescale 1ns/1ps
module line_filter #(
    parameter int WIDTH = 1,
    parameter int FILT_LEN = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] line_i,
    output logic [WIDTH-1:0] line_o
);
    localparam int CNT_W = $clog2(FILT_LEN + 1);

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_ff;
        logic sync_ff;
        logic out_ff;
        logic [CNT_W-1:0] cnt_ff;

        // Only sync_ff reads the first stage
        always_ff @(posedge core_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                meta_ff <= RST_VAL[i];
                sync_ff <= RST_VAL[i];
            end else begin
                meta_ff <= line_i[i];
                sync_ff <= meta_ff;
            end
        end

        // A new level must hold FILT_LEN cycles before it is passed on
        always_ff @(posedge core_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                out_ff <= RST_VAL[i];
                cnt_ff <= '0;
            end else if (sync_ff != out_ff) begin
                if (cnt_ff == CNT_W'(FILT_LEN - 1)) begin
                    out_ff <= sync_ff;
                    cnt_ff <= '0;
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end else begin
                cnt_ff <= '0;
            end
        end

        assign line_o[i] = out_ff;
    end

endmodule : line_filter

// ---- rtl/serial_eeprom_bus_slave.sv ----
// Summary of operation
// - SDA falling while SCL high is a start and opens a new command.
// - Before a start, all bus activity is ignored and SDA is released.
// - Any SDA change while SCL is high is start or stop, never data.
// - One SCL pulse per bit, sampled while SCL high, only after a start.
// - SDA is open drain: pulled low or released.
// - Three select inputs form the bus address, eight devices per bus.
// - An unconnected select input reads as zero.
// - Write protect high blocks all array writes; low allows them.
// - 8192 bytes in 32-byte pages; address is page plus 5-bit offset.
// - Page writes take up to 32 bytes, shorter ones allowed.
// - Programming is self timed and ends within 5 ms.
// - Reset ignores commands, then resets the state machine to standby.
// - A stop enters standby unless an internal write is running.
// - Writes parse as slave byte, then address, then data; reads as slave byte, then data.
// - SDA rising while SCL high is a stop and ends the operation.
// - Slave byte: type code, three select bits, read/write bit.
// - Eight bits addressed to the device are acknowledged on the ninth clock.
// - While programming, the slave byte is not acknowledged.
`timescale 1ns/1ps
module serial_eeprom_bus_slave import eeprom_pkg::*; #(
    parameter int PROG_CYCLES = PROG_CYCLES_DEF,
    parameter int FILT_LEN = FILT_CYCLES_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_b_o,
    input wire logic device_select_bit0_i,
    input wire logic device_select_bit1_i,
    input wire logic device_select_bit2_i,
    input wire logic write_protect_i,
    output logic standby_o,
    output logic write_busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input conditioning
    logic scl_f;
    logic sda_f;
    logic [3:0] strap;
    logic wp_s;
    logic [SEL_W-1:0] sel_s;

    line_filter #(
        .WIDTH(2),
        .FILT_LEN(FILT_LEN),
        .RST_VAL(BUS_RST_VAL)
    ) u_bus_filt (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .line_i({scl_i, sda_i}),
        .line_o({scl_f, sda_f})
    );

    // Straps are static, so a two-stage sync plus a one-cycle filter stage is enough
    line_filter #(
        .WIDTH(4),
        .FILT_LEN(1),
        .RST_VAL(STRAP_RST_VAL)
    ) u_strap_sync (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .line_i({write_protect_i, device_select_bit2_i, device_select_bit1_i, device_select_bit0_i}),
        .line_o(strap)
    );

    assign wp_s = strap[3];
    assign sel_s = strap[SEL_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Bus events
    logic scl_q_ff;
    logic sda_q_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_f;
            sda_q_ff <= sda_f;
        end
    end

    assign scl_rise = scl_f & ~scl_q_ff;
    assign scl_fall = ~scl_f & scl_q_ff;
    assign start_ev = scl_f & scl_q_ff & sda_q_ff & ~sda_f;
    assign stop_ev = scl_f & scl_q_ff & ~sda_q_ff & sda_f;

    ////////////////////////////////////////////////////////////////////////
    // Byte framing
    bus_state_e state_ff;
    logic [3:0] bit_cnt_ff;
    logic [BYTE_W-1:0] shreg_ff;
    logic [BYTE_W-1:0] tx_ff;
    logic rw_ff;
    logic m_ack_ff;
    logic busy_ff;
    logic in_frame;
    logic byte_done;
    logic ack_done;
    logic dev_match;
    logic ack_now;
    logic load_tx;
    logic fifo_valid;
    logic [BYTE_W-1:0] fifo_data;

    assign in_frame = state_ff != ST_IDLE;
    assign byte_done = in_frame & scl_fall & (bit_cnt_ff == LAST_DATA_BIT);
    assign ack_done = in_frame & scl_fall & (bit_cnt_ff == ACK_BIT);
    assign dev_match = (shreg_ff[TYPE_MSB:TYPE_LSB] == DEV_TYPE)
                     & (shreg_ff[SEL_MSB:SEL_LSB] == sel_s);
    assign ack_now = ((state_ff == ST_DEVSEL) & dev_match & ~busy_ff)
                   | (state_ff == ST_ADDR_HI) | (state_ff == ST_ADDR_LO)
                   | (state_ff == ST_WDATA);
    assign load_tx = ack_done & (((state_ff == ST_DEVSEL) & rw_ff)
                   | ((state_ff == ST_RDATA) & m_ack_ff));

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= '0;
        end else if (start_ev) begin
            state_ff <= ST_DEVSEL;
            bit_cnt_ff <= '1;
        end else if (stop_ev) begin
            state_ff <= ST_IDLE;
        end else if (in_frame) begin
            if (byte_done) begin
                bit_cnt_ff <= ACK_BIT;
                if ((state_ff == ST_DEVSEL) && !ack_now) begin
                    state_ff <= ST_IDLE;
                end
            end else if (ack_done) begin
                bit_cnt_ff <= '0;
                unique case (state_ff)
                    ST_DEVSEL: state_ff <= rw_ff ? ST_RDATA : ST_ADDR_HI;
                    ST_ADDR_HI: state_ff <= ST_ADDR_LO;
                    ST_ADDR_LO: state_ff <= ST_WDATA;
                    ST_WDATA: state_ff <= ST_WDATA;
                    ST_RDATA: state_ff <= m_ack_ff ? ST_RDATA : ST_IDLE;
                    default: state_ff <= ST_IDLE;
                endcase
            end else if (scl_fall) begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
        end
    end

    // Data is taken on the SCL rise, when the master holds it steady
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shreg_ff <= '0;
            m_ack_ff <= 1'b0;
        end else if (in_frame && scl_rise) begin
            if (bit_cnt_ff < ACK_BIT) begin
                shreg_ff <= {shreg_ff[BYTE_W-2:0], sda_f};
            end else if (state_ff == ST_RDATA) begin
                m_ack_ff <= ~sda_f;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rw_ff <= 1'b0;
        end else if (byte_done && state_ff == ST_DEVSEL) begin
            rw_ff <= shreg_ff[RW_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain SDA; oe low pulls the line low
    logic sda_oe_b_ff;
    logic sda_o_ff;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sda_oe_b_ff <= 1'b1;
        end else if (start_ev || stop_ev || !in_frame) begin
            sda_oe_b_ff <= 1'b1;
        end else if (byte_done) begin
            sda_oe_b_ff <= ~ack_now;
        end else if (ack_done) begin
            sda_oe_b_ff <= load_tx ? fifo_data[BYTE_W-1] : 1'b1;
        end else if (scl_fall && state_ff == ST_RDATA && bit_cnt_ff < LAST_DATA_BIT) begin
            sda_oe_b_ff <= tx_ff[BYTE_W-2];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_ff <= '0;
        end else if (load_tx) begin
            tx_ff <= fifo_data;
        end else if (scl_fall && state_ff == ST_RDATA) begin
            tx_ff <= {tx_ff[BYTE_W-2:0], 1'b1};
        end
    end

    // The pad only ever pulls low
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sda_o_ff <= 1'b0;
        end else begin
            sda_o_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address pointer
    logic [ADDR_W-1:0] addr_ff;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_ff <= '0;
        end else if (byte_done) begin
            unique case (state_ff)
                ST_ADDR_HI: addr_ff[ADDR_W-1:BYTE_W] <= shreg_ff[ADDR_HI_W-1:0];
                ST_ADDR_LO: addr_ff[BYTE_W-1:0] <= shreg_ff;
                ST_WDATA: addr_ff[OFF_W-1:0] <= addr_ff[OFF_W-1:0] + 1'b1;
                default: addr_ff <= addr_ff;
            endcase
        end else if (load_tx) begin
            addr_ff <= addr_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Page buffer
    logic [BYTE_W-1:0] pg_buf_ff [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pg_valid_ff;
    logic wr_pend_ff;

    always_ff @(posedge core_clk_i) begin
        if (byte_done && state_ff == ST_WDATA) begin
            pg_buf_ff[addr_ff[OFF_W-1:0]] <= shreg_ff;
        end
    end

    // Bytes past 32 wrap onto the same page and overwrite earlier ones
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pg_valid_ff <= '0;
            wr_pend_ff <= 1'b0;
        end else if (start_ev || stop_ev) begin
            wr_pend_ff <= 1'b0;
        end else if (byte_done && state_ff == ST_ADDR_LO) begin
            pg_valid_ff <= '0;
        end else if (byte_done && state_ff == ST_WDATA) begin
            pg_valid_ff[addr_ff[OFF_W-1:0]] <= 1'b1;
            wr_pend_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Self-timed programming
    logic [31:0] prog_cnt_ff;
    logic [BYTE_W-1:0] mem_ff [MEM_BYTES];
    logic [OFF_W-1:0] commit_off;

    assign commit_off = prog_cnt_ff[OFF_W-1:0];

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_ff <= 1'b0;
            prog_cnt_ff <= '0;
        end else if (busy_ff) begin
            if (prog_cnt_ff == 32'(PROG_CYCLES - 1)) begin
                busy_ff <= 1'b0;
            end else begin
                prog_cnt_ff <= prog_cnt_ff + 32'h1;
            end
        end else if (stop_ev && wr_pend_ff && !wp_s) begin
            busy_ff <= 1'b1;
            prog_cnt_ff <= '0;
        end
    end

    // One byte per cycle at the start of the window keeps a single write port
    always_ff @(posedge core_clk_i) begin
        if (busy_ff && prog_cnt_ff < 32'(PAGE_BYTES) && pg_valid_ff[commit_off]) begin
            mem_ff[{addr_ff[ADDR_W-1:OFF_W], commit_off}] <= pg_buf_ff[commit_off];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read prefetch into the FIFO
    logic [ADDR_W-1:0] pf_addr_ff;
    logic pf_valid;
    logic pf_ready;

    // The array is frozen while programming, so prefetch waits
    assign pf_valid = ~busy_ff;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pf_addr_ff <= '0;
        end else if (start_ev) begin
            pf_addr_ff <= addr_ff;
        end else if (pf_valid && pf_ready) begin
            pf_addr_ff <= pf_addr_ff + 1'b1;
        end
    end

    byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rd_fifo (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(start_ev),
        .in_valid_i(pf_valid),
        .in_ready_o(pf_ready),
        .in_data_i(mem_ff[pf_addr_ff]),
        .out_valid_o(fifo_valid),
        .out_ready_i(load_tx),
        .out_data_o(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status
    logic standby_ff;
    logic busy_o_ff;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            standby_ff <= 1'b1;
            busy_o_ff <= 1'b0;
        end else begin
            standby_ff <= ~in_frame & ~busy_ff;
            busy_o_ff <= busy_ff;
        end
    end

    assign sda_o = sda_o_ff;
    assign sda_oe_b_o = sda_oe_b_ff;
    assign standby_o = standby_ff;
    assign write_busy_o = busy_o_ff;

endmodule : serial_eeprom_bus_slave

// ---- verif/bus_master_model.sv ----
`timescale 1ns/1ps
module bus_master_model (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Quarter of the 125 ns bus period; kept free of the core clock phase
    localparam realtime Q = 31.25;

    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic bit_io(input logic b, output logic r);
        sda_low_o = !b;
        #Q scl_o = 1'b1;
        #Q r = sda_i;
        #Q scl_o = 1'b0;
        #Q;
    endtask : bit_io

    task automatic start();
        sda_low_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b1;
        #Q scl_o = 1'b0;
        #Q;
    endtask : start

    task automatic stop();
        sda_low_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b0;
        #(2 * Q);
    endtask : stop

    task automatic lower();
        scl_o = 1'b0;
        #Q;
    endtask : lower

    task automatic glitch(input realtime w);
        sda_low_o = 1'b1;
        #w sda_low_o = 1'b0;
        #Q;
    endtask : glitch

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : send_byte

    task automatic recv_byte(output logic [7:0] d, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask : recv_byte
endmodule : bus_master_model

// ---- verif/serial_eeprom_bus_slave_asserts.sv ----
`timescale 1ns/1ps
module serial_eeprom_bus_slave_asserts import eeprom_pkg::*; #(
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_b_o,
    input wire logic device_select_bit0_i,
    input wire logic device_select_bit1_i,
    input wire logic device_select_bit2_i,
    input wire logic write_protect_i,
    input wire logic standby_o,
    input wire logic write_busy_o
);
    // Cycles spent so far in the current programming window
    int busy_len_ff;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_len_ff <= 0;
        end else begin
            busy_len_ff <= write_busy_o ? busy_len_ff + 1 : 0;
        end
    end

    default clocking cb_core @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////////
    // Two quiet samples after the edge, so a filter-sized spike is no frame edge
    sequence s_pin_start;
        scl_i && $fell(sda_i) ##1 (scl_i && !sda_i) [*2];
    endsequence
    sequence s_pin_stop;
        scl_i && $rose(sda_i) ##1 (scl_i && sda_i) [*2];
    endsequence

    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda_o driven high");
    property p_reset_exit;
        $rose(rst_b_i) |-> standby_o && sda_oe_b_o && !write_busy_o;
    endproperty
    a_reset_exit: assert property (p_reset_exit) else $error("not idle after reset");
    property p_busy_bound;
        write_busy_o |-> busy_len_ff < PROG_CYCLES;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("programming too long");
    property p_idle_released;
        standby_o |-> sda_oe_b_o;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("sda pulled in standby");
    property p_busy_no_ack;
        write_busy_o |-> sda_oe_b_o && !standby_o;
    endproperty
    a_busy_no_ack: assert property (p_busy_no_ack) else $error("sda pulled while busy");
    property p_drive_scl_low;
        $fell(sda_oe_b_o) |-> !$past(scl_i, 1) && !$past(scl_i, 4);
    endproperty
    a_drive_scl_low: assert property (p_drive_scl_low) else $error("sda pulled with scl high");
    property p_start_opens;
        s_pin_start |-> ##[1:10] !standby_o;
    endproperty
    a_start_opens: assert property (p_start_opens) else $error("start not taken");
    property p_stop_ends;
        s_pin_stop |-> ##[1:12] (standby_o || write_busy_o);
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("stop not taken");
endmodule : serial_eeprom_bus_slave_asserts

bind serial_eeprom_bus_slave serial_eeprom_bus_slave_asserts #(.PROG_CYCLES(PROG_CYCLES))
    i_serial_eeprom_bus_slave_asserts (.core_clk_i, .rst_b_i, .scl_i, .sda_i, .sda_o, .sda_oe_b_o,
    .device_select_bit0_i, .device_select_bit1_i, .device_select_bit2_i, .write_protect_i,
    .standby_o, .write_busy_o);

// ---- verif/serial_eeprom_bus_slave_test.sv ----
`timescale 1ns/1ps
module serial_eeprom_bus_slave_test import eeprom_pkg::*;;
    // Window long enough to hold a whole polling frame
    localparam int PROG = 400;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] sel = 3'h0;
    logic wp = 1'b0;
    logic scl;
    logic m_low;
    logic sda_o;
    logic oe_b;
    logic standby;
    logic busy;
    int fail_count = 0;
    int check_count = 0;
    // Pull-up: high unless a party pulls low
    wire logic sda = !m_low && (oe_b || sda_o);

    always #4 clk = !clk;

    serial_eeprom_bus_slave #(.PROG_CYCLES(PROG)) i_serial_eeprom_bus_slave (.core_clk_i(clk),
        .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_b_o(oe_b),
        .device_select_bit0_i(sel[0]), .device_select_bit1_i(sel[1]), .device_select_bit2_i(sel[2]),
        .write_protect_i(wp), .standby_o(standby), .write_busy_o(busy));
    bus_master_model i_bus_master_model (.sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

    ////////////////////////////////////////////////////////////////////////
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic close_out();
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    function automatic logic [7:0] slave(input logic rw);
        return {DEV_TYPE_DEF, sel, rw};
    endfunction : slave

    task automatic wait_busy(input logic lvl, input int bound);
        for (int i = 0; i < bound && busy !== lvl; i++) begin
            cycles(1);
        end
        check_bit("write_busy_o", lvl, busy);
        if (busy !== lvl) begin
            close_out();
        end
    endtask : wait_busy

    task automatic probe(input logic [7:0] b, input logic exp);
        logic ack;
        i_bus_master_model.start();
        i_bus_master_model.send_byte(b, ack);
        i_bus_master_model.stop();
        check_bit("slave ack", exp, ack);
    endtask : probe

    task automatic address(input logic [12:0] a);
        logic ack;
        i_bus_master_model.start();
        i_bus_master_model.send_byte(slave(1'b0), ack);
        check_bit("slave ack", 1'b1, ack);
        i_bus_master_model.send_byte({3'h0, a[12:8]}, ack);
        check_bit("addr hi ack", 1'b1, ack);
        i_bus_master_model.send_byte(a[7:0], ack);
        check_bit("addr lo ack", 1'b1, ack);
    endtask : address

    task automatic write_bytes(input logic [12:0] a, input int n, input logic [7:0] base);
        logic ack;
        address(a);
        for (int i = 0; i < n; i++) begin
            i_bus_master_model.send_byte(base + 8'(8'h11 * i), ack);
            check_bit("data ack", 1'b1, ack);
        end
        i_bus_master_model.stop();
    endtask : write_bytes

    task automatic read_bytes(input logic rnd, input logic [12:0] a, input int n, input logic [7:0] e0,
        input logic [7:0] e1);
        logic ack;
        logic [7:0] d;
        if (rnd) begin
            address(a);
        end
        i_bus_master_model.start();
        i_bus_master_model.send_byte(slave(1'b1), ack);
        check_bit("read ack", 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            i_bus_master_model.recv_byte(d, i == n - 1);
            check_byte("read data", (i == 0) ? e0 : e1, d);
        end
        i_bus_master_model.stop();
    endtask : read_bytes

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        probe(slave(1'b0), 1'b1);
        i_bus_master_model.start();
        cycles(1);
        rst_b = 1'b0;
        cycles(2);
        check_bit("standby_o", 1'b1, standby);
        check_bit("sda_oe_b_o", 1'b1, oe_b);
        check_bit("write_busy_o", 1'b0, busy);
        rst_b = 1'b1;
        i_bus_master_model.stop();
        cycles(12);
    endtask : t_reset

    task automatic t_straps();
        // Ends at zero so later scenarios see the unconnected case
        for (int s = 7; s >= 0; s--) begin
            cycles(1);
            sel = 3'(s);
            cycles(4);
            probe(slave(1'b0), 1'b1);
            probe({DEV_TYPE_DEF, sel ^ 3'h4, 1'b0}, 1'b0);
            probe({~DEV_TYPE_DEF, sel, 1'b0}, 1'b0);
        end
    endtask : t_straps

    task automatic t_no_start();
        logic ack;
        i_bus_master_model.glitch(10.0);
        cycles(10);
        check_bit("standby_o", 1'b1, standby);
        i_bus_master_model.lower();
        i_bus_master_model.send_byte(slave(1'b0), ack);
        check_bit("ack without start", 1'b0, ack);
        i_bus_master_model.stop();
        cycles(12);
    endtask : t_no_start

    task automatic t_page_wrap();
        write_bytes(13'h003E, 4, 8'h5A);
        wait_busy(1'b1, 40);
        check_bit("standby_o", 1'b0, standby);
        probe(slave(1'b0), 1'b0);
        wait_busy(1'b0, PROG + 20);
        check_bit("standby_o", 1'b1, standby);
        read_bytes(1'b1, 13'h003E, 1, 8'h5A, 8'h5A);
        read_bytes(1'b0, 13'h0000, 1, 8'h6B, 8'h6B);
        read_bytes(1'b1, 13'h0020, 2, 8'h7C, 8'h8D);
    endtask : t_page_wrap

    task automatic t_protect();
        cycles(1);
        wp = 1'b1;
        cycles(4);
        write_bytes(13'h003E, 1, 8'h00);
        cycles(PROG + 20);
        wp = 1'b0;
        cycles(4);
        read_bytes(1'b1, 13'h003E, 1, 8'h5A, 8'h5A);
        write_bytes(13'h003E, 1, 8'hC3);
        wait_busy(1'b1, 40);
        wait_busy(1'b0, PROG + 20);
        read_bytes(1'b1, 13'h003E, 1, 8'hC3, 8'hC3);
    endtask : t_protect

    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        cycles(12);
        t_reset();
        t_straps();
        t_no_start();
        t_page_wrap();
        t_protect();
        close_out();
    end
endmodule : serial_eeprom_bus_slave_test
